// ===== hdl/maf_top.v
// station address, group hash filter and phy management register block
// Behaviour
// (R1) high address register keeps bits 47:32, resets ones
// (R2) low address register keeps bits 31:0, resets ones
// (R3) first received octet matches low bits 7:0
// (R4) address registers reset only by guard reset
// (R5) six-bit index selects hash register and bit
// (R6) index zero is low bit 0
// (R7) group frame accepted when hash bit set
// (R8) accept-all-group accepts every group frame
// (R9) two writable hash registers, reset zero
// (R10) software writes phy address one always
// (R11) index field 10:6 selects phy register
// (R12) write-select chooses phy write or read
// (R13) pending bit starts cycle, device clears it
// (R14) software waits for pending clear first
// (R15) software keeps data steady during write
// (R16) read data valid once pending clears
// (R17) sixteen-bit data field, upper half zero
// (R18) cycles run as clause 22 frames
`timescale 1ns/100ps
`default_nettype none
`include "maf_map.vh"

module maf_top (
    // clock and resets
    input wire core_clk,
    input wire rst_n,
    input wire guard_rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // receive address check request
    input wire rx_check,
    input wire [47:0] rx_dest_addr,
    input wire [5:0] rx_hash_index,
    // receive address check result
    output reg rx_result_valid_r,
    output reg rx_station_match_r,
    output reg rx_group_frame_r,
    output reg rx_group_accept_r,
    // phy management pins
    output wire mdc,
    output wire mdio_o,
    output wire mdio_oe,
    input wire mdio_i
);

    // station words have their own reset so
    // an ordinary reset keeps the address

    // registers reset by the ordinary reset
    reg accept_all_group_r; // filter control bit
    reg [31:0] group_hash_high_r; // upper hash half
    reg [31:0] group_hash_low_r; // lower hash half
    reg [4:0] phy_addr_r; // phy address field
    reg [4:0] phy_reg_index_r; // phy register index
    reg phy_write_select_r; // one for a phy write
    reg phy_access_pending_r; // cycle in progress
    reg [15:0] phy_mgmt_word_r; // management data
    reg mgmt_start_r; // one-cycle start to the engine

    // registers held by the guard reset
    // upper half of the high word reads zero
    reg [15:0] station_addr_high_r; // address bits 47:32
    reg [31:0] station_addr_low_r; // address bits 31:0

    // bus decode
    // address decode is combinational from paddr
    wire setup_ph; // first cycle of a transfer
    wire acc_ph; // completing access cycle
    wire wr_en; // write takes effect now
    wire [31:0] rd_nxt; // read value for the address
    wire hit_nxt; // address is mapped
    wire mgmt_done; // engine finished a frame
    wire [15:0] mgmt_rdata; // data read from the phy

    // hash lookup: msb picks half, low five bits pick the bit
    // index 0 is low bit 0, 63 high bit 31
    function hash_bit;
        input [5:0] idx;
        input [31:0] hi;
        input [31:0] lo;
        begin
            // see R5
            // see R6
            hash_bit = idx[5] ? hi[idx[4:0]] : lo[idx[4:0]];
        end
    endfunction

    // address decode used for read data and write steering
    // exact word match, no aliasing
    function is_reg;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            is_reg = (addr == ofs);
        end
    endfunction

    // zero wait states: access follows setup
    // writes to unmapped offsets are dropped
    assign setup_ph = psel && !penable;
    assign acc_ph = psel && penable && pready;
    assign wr_en = acc_ph && pwrite && !pslverr;

    // mapped address check
    // any other offset answers pslverr
    assign hit_nxt = is_reg(paddr, `MAF_OFS_FILTER_CTRL) ||
        is_reg(paddr, `MAF_OFS_STATION_HIGH) ||
        is_reg(paddr, `MAF_OFS_STATION_LOW) ||
        is_reg(paddr, `MAF_OFS_HASH_HIGH) ||
        is_reg(paddr, `MAF_OFS_HASH_LOW) ||
        is_reg(paddr, `MAF_OFS_MGMT_CMD) ||
        is_reg(paddr, `MAF_OFS_MGMT_WORD);

    // read multiplexer; reserved bits read zero
    // unmapped offsets fall through to zero
    assign rd_nxt =
        is_reg(paddr, `MAF_OFS_FILTER_CTRL) ?
            {31'h00000000, accept_all_group_r} :
        is_reg(paddr, `MAF_OFS_STATION_HIGH) ?
            {16'h0000, station_addr_high_r} : // see R1
        is_reg(paddr, `MAF_OFS_STATION_LOW) ?
            station_addr_low_r : // see R2
        is_reg(paddr, `MAF_OFS_HASH_HIGH) ? group_hash_high_r :
        is_reg(paddr, `MAF_OFS_HASH_LOW) ? group_hash_low_r :
        is_reg(paddr, `MAF_OFS_MGMT_CMD) ?
            {16'h0000, phy_addr_r, phy_reg_index_r, 4'h0,
             phy_write_select_r, phy_access_pending_r} :
        is_reg(paddr, `MAF_OFS_MGMT_WORD) ?
            {16'h0000, phy_mgmt_word_r} : // see R17
        32'h00000000;

    // apb answer: ready and data registered in the setup cycle
    // prdata is zero outside a read access
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // no answer pending after reset
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (setup_ph) begin
            // answer at the first access edge
            pready <= 1'b1;
            pslverr <= !hit_nxt;
            prdata <= pwrite ? 32'h00000000 : rd_nxt;
        end else begin
            // drop after the access completes
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    // station address, set to ones only by the guard reset
    always @(posedge core_clk or negedge guard_rst_n) begin
        if (!guard_rst_n) begin
            // see R4
            station_addr_high_r <= `MAF_RST_STATION_HIGH; // see R1
            station_addr_low_r <= `MAF_RST_STATION_LOW; // see R2
        end else if (wr_en) begin
            // upper half of the high word is not stored
            if (is_reg(paddr, `MAF_OFS_STATION_HIGH)) begin
                station_addr_high_r <= pwdata[15:0]; // see R1
            end
            if (is_reg(paddr, `MAF_OFS_STATION_LOW)) begin
                station_addr_low_r <= pwdata; // see R2
            end
        end
    end

    // hash table and filter control
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // empty table rejects group frames
            group_hash_high_r <= `MAF_RST_HASH; // see R9
            group_hash_low_r <= `MAF_RST_HASH; // see R9
            accept_all_group_r <= 1'b0;
        end else if (wr_en) begin
            // each half takes the whole word
            if (is_reg(paddr, `MAF_OFS_HASH_HIGH)) begin
                group_hash_high_r <= pwdata; // see R9
            end
            if (is_reg(paddr, `MAF_OFS_HASH_LOW)) begin
                group_hash_low_r <= pwdata; // see R9
            end
            if (is_reg(paddr, `MAF_OFS_FILTER_CTRL)) begin
                accept_all_group_r <= pwdata[`MAF_FC_ACCEPT_ALL];
            end
        end
    end

    // management command and pending flag
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // no cycle pending after reset
            phy_addr_r <= `MAF_RST_FIELD5;
            phy_reg_index_r <= `MAF_RST_FIELD5;
            phy_write_select_r <= 1'b0;
            phy_access_pending_r <= 1'b0;
            mgmt_start_r <= 1'b0;
        end else begin
            mgmt_start_r <= 1'b0;
            if (phy_access_pending_r) begin
                // writes while pending are ignored; done clears the flag
                // set and clear never meet in a cycle
                if (mgmt_done) begin
                    phy_access_pending_r <= 1'b0; // see R13
                end
            end else if (wr_en && is_reg(paddr, `MAF_OFS_MGMT_CMD)) begin
                // address written as given by software (see R10)
                phy_addr_r <= pwdata[`MAF_CMD_PHY_HI:`MAF_CMD_PHY_LO];
                phy_reg_index_r <=
                    pwdata[`MAF_CMD_IDX_HI:`MAF_CMD_IDX_LO]; // see R11
                phy_write_select_r <= pwdata[`MAF_CMD_WRITE]; // see R12
                // setting the pending bit launches a cycle
                // no second start while the flag is up
                if (pwdata[`MAF_CMD_PENDING]) begin
                    phy_access_pending_r <= 1'b1; // see R13
                    mgmt_start_r <= 1'b1;
                end
            end
        end
    end

    // management data word: software writes or phy read result
    // bus writes land only while idle
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // cleared by the ordinary reset
            phy_mgmt_word_r <= `MAF_RST_MGMT_WORD; // see R17
        end else if (phy_access_pending_r) begin
            // result lands in the same edge the flag clears
            // a phy write leaves the word alone
            if (mgmt_done && !phy_write_select_r) begin
                phy_mgmt_word_r <= mgmt_rdata; // see R16
            end
        end else if (wr_en && is_reg(paddr, `MAF_OFS_MGMT_WORD)) begin
            // writes only accepted while idle (see R14)
            phy_mgmt_word_r <= pwdata[15:0]; // see R17
        end
    end

    // receive destination check, one result cycle per request
    // hash index comes from the receive path
    // results return to zero after a cycle
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // no result pending after reset
            rx_result_valid_r <= 1'b0;
            rx_station_match_r <= 1'b0;
            rx_group_frame_r <= 1'b0;
            rx_group_accept_r <= 1'b0;
        end else begin
            rx_result_valid_r <= rx_check;
            if (rx_check) begin
                // all six octets compared at once
                // octet one sits in dest bits 7:0 (see R3)
                rx_station_match_r <=
                    (rx_dest_addr[31:0] == station_addr_low_r) &&
                    (rx_dest_addr[47:32] == station_addr_high_r);
                // group bit is the lsb of the first octet
                rx_group_frame_r <= rx_dest_addr[0];
                rx_group_accept_r <= rx_dest_addr[0] &&
                    (accept_all_group_r || // see R8
                     hash_bit(rx_hash_index, group_hash_high_r,
                              group_hash_low_r)); // see R7
            end else begin
                rx_station_match_r <= 1'b0;
                rx_group_frame_r <= 1'b0;
                rx_group_accept_r <= 1'b0;
            end
        end
    end

    // frame engine; its pin outputs are flip-flops
    // it copies fields at start, so a later
    // bus write cannot disturb a frame
    maf_mdio u_mdio (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(mgmt_start_r),
        .wr_sel(phy_write_select_r),
        .phy_addr(phy_addr_r),
        .reg_idx(phy_reg_index_r),
        .wdata(phy_mgmt_word_r), // held steady (see R15)
        .done_r(mgmt_done),
        .rdata_r(mgmt_rdata),
        .mdc_r(mdc),
        .mdio_o_r(mdio_o),
        .mdio_oe_r(mdio_oe),
        .mdio_i(mdio_i)
    );

endmodule // maf_top

`default_nettype wire

// ===== hdl/maf_map.vh
// register map, field positions, reset values and timing counts
`ifndef MAF_MAP_VH
`define MAF_MAP_VH

// register byte offsets
`define MAF_OFS_FILTER_CTRL 12'h0F8
`define MAF_OFS_STATION_HIGH 12'h104
`define MAF_OFS_STATION_LOW 12'h108
`define MAF_OFS_HASH_HIGH 12'h10C
`define MAF_OFS_HASH_LOW 12'h110
`define MAF_OFS_MGMT_CMD 12'h114
`define MAF_OFS_MGMT_WORD 12'h118

// reset values
`define MAF_RST_STATION_HIGH 16'hFFFF
`define MAF_RST_STATION_LOW 32'hFFFFFFFF
`define MAF_RST_HASH 32'h00000000
`define MAF_RST_MGMT_WORD 16'h0000
`define MAF_RST_FIELD5 5'h00

// filter control fields
`define MAF_FC_ACCEPT_ALL 0

// management command fields
`define MAF_CMD_PHY_HI 15
`define MAF_CMD_PHY_LO 11
`define MAF_CMD_IDX_HI 10
`define MAF_CMD_IDX_LO 6
`define MAF_CMD_WRITE 1
`define MAF_CMD_PENDING 0

// management frame layout, bit positions counted from frame start
`define MAF_MDIO_FRAME_BITS 64
`define MAF_MDIO_LAST_BIT 6'h3F
`define MAF_MDIO_TA_BIT 6'h2E
`define MAF_MDIO_DATA_BIT 6'h30
`define MAF_MDIO_PREAMBLE 32'hFFFFFFFF
`define MAF_MDIO_START 2'h1
`define MAF_MDIO_OP_WRITE 2'h1
`define MAF_MDIO_OP_READ 2'h2
`define MAF_MDIO_TA_WRITE 2'h2
`define MAF_MDIO_TA_READ 2'h3

// management clock: least half period in ns, core clock period in ns
`define MAF_MDC_HALF_NS 200
`define MAF_CLK_PERIOD_NS 20
`define MAF_MDC_HALF_CYC ((`MAF_MDC_HALF_NS + `MAF_CLK_PERIOD_NS - 1) / `MAF_CLK_PERIOD_NS)

`endif

// ===== hdl/maf_mdio.v
// serial management frame engine toward the internal phy
`timescale 1ns/100ps
`default_nettype none
`include "maf_map.vh"

module maf_mdio (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // command from the register file
    input wire start,
    input wire wr_sel,
    input wire [4:0] phy_addr,
    input wire [4:0] reg_idx,
    input wire [15:0] wdata,
    // completion
    output reg done_r,
    output reg [15:0] rdata_r,
    // management pins
    output reg mdc_r,
    output reg mdio_o_r,
    output reg mdio_oe_r,
    input wire mdio_i
);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;
    localparam integer HALF_CYC = `MAF_MDC_HALF_CYC; // cycles a half
    localparam [7:0] HALF_M1 = HALF_CYC[7:0] - 8'h01; // divider end

    reg state_r; // engine state
    reg wr_r; // write cycle in progress
    reg [7:0] div_r; // half period divider
    reg [5:0] bit_r; // index of bit on the wire
    reg [63:0] sh_r; // outgoing frame, msb first

    // frame sequencer: drive on falling mdc, sample on rising mdc
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            wr_r <= 1'b0;
            div_r <= 8'h00;
            bit_r <= 6'h00;
            sh_r <= 64'h0000000000000000;
            done_r <= 1'b0;
            rdata_r <= 16'h0000;
            mdc_r <= 1'b0;
            mdio_o_r <= 1'b0;
            mdio_oe_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    // build a clause 22 style frame (see R18)
                    if (start) begin
                        state_r <= ST_RUN;
                        wr_r <= wr_sel;
                        div_r <= 8'h00;
                        bit_r <= 6'h00;
                        sh_r <= {`MAF_MDIO_PREAMBLE, `MAF_MDIO_START,
                            wr_sel ? `MAF_MDIO_OP_WRITE : `MAF_MDIO_OP_READ,
                            phy_addr, reg_idx,
                            wr_sel ? `MAF_MDIO_TA_WRITE : `MAF_MDIO_TA_READ,
                            wdata};
                        mdc_r <= 1'b0;
                        mdio_o_r <= 1'b1;
                        mdio_oe_r <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (div_r == HALF_M1) begin
                        div_r <= 8'h00;
                        mdc_r <= ~mdc_r;
                        if (!mdc_r) begin
                            // rising edge: capture read data bits
                            if (!wr_r && bit_r >= `MAF_MDIO_DATA_BIT) begin
                                rdata_r <= {rdata_r[14:0], mdio_i};
                            end
                        end else if (bit_r == `MAF_MDIO_LAST_BIT) begin
                            // falling edge after last bit ends the frame
                            state_r <= ST_IDLE;
                            done_r <= 1'b1;
                            mdio_oe_r <= 1'b0;
                            mdio_o_r <= 1'b0;
                        end else begin
                            // falling edge: present next bit
                            bit_r <= bit_r + 6'h01;
                            sh_r <= {sh_r[62:0], 1'b0};
                            mdio_o_r <= sh_r[62];
                            mdio_oe_r <= wr_r ||
                                (bit_r + 6'h01 < `MAF_MDIO_TA_BIT);
                        end
                    end else begin
                        div_r <= div_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // maf_mdio

`default_nettype wire

// ===== verification/maf_chk.sv
// assertion checker for the filter and management register block
`timescale 1ns/100ps
`default_nettype none
module maf_chk (
    // clock and resets
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic guard_rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // receive check
    input wire logic rx_check,
    input wire logic [47:0] rx_dest_addr,
    input wire logic [5:0] rx_hash_index,
    input wire logic rx_result_valid_r,
    input wire logic rx_station_match_r,
    input wire logic rx_group_frame_r,
    input wire logic rx_group_accept_r,
    // management pins
    input wire logic mdc,
    input wire logic mdio_o,
    input wire logic mdio_oe,
    input wire logic mdio_i
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [63:0] tbl_r; // shadow hash table
    logic [47:0] sta_r; // shadow station address
    logic aa_r; // shadow accept-all-group
    logic acc_r; // expected group accept
    logic sm_r; // expected station match
    logic wr; // completed write
    logic mapped; // address decodes
    assign wr = psel && penable && pready && pwrite;
    assign mapped = paddr inside {12'h0F8, 12'h104, 12'h108, 12'h10C,
        12'h110, 12'h114, 12'h118};
    // hash shadow and expectations follow completed writes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tbl_r <= 64'h0;
            aa_r <= 1'b0;
            acc_r <= 1'b0;
            sm_r <= 1'b0;
        end else begin
            if (wr && paddr == 12'h10C) tbl_r[63:32] <= pwdata;
            if (wr && paddr == 12'h110) tbl_r[31:0] <= pwdata;
            if (wr && paddr == 12'h0F8) aa_r <= pwdata[0];
            acc_r <= rx_dest_addr[0] && (aa_r || tbl_r[rx_hash_index]);
            sm_r <= rx_dest_addr == sta_r;
        end
    end
    // station shadow only set to ones by the guard reset
    always_ff @(posedge core_clk or negedge guard_rst_n) begin
        if (!guard_rst_n) sta_r <= 48'hFFFFFFFFFFFF;
        else if (wr && paddr == 12'h104) sta_r[47:32] <= pwdata[15:0];
        else if (wr && paddr == 12'h108) sta_r[31:0] <= pwdata;
    end
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held");
    a_err_unmap: assert property (psel && !penable && !mapped
        |=> pready && pslverr && prdata == 32'h0) else $error("unmapped");
    a_hash_read: assert property (
        pready && !pwrite && paddr == 12'h10C |-> prdata == tbl_r[63:32])
        else $error("hash high read");
    a_resv_zero: assert property (
        pready && !pwrite && (paddr == 12'h104 || paddr == 12'h118)
        |-> prdata[31:16] == 16'h0000) else $error("reserved bits");
    a_rx_valid: assert property (rx_check |=> rx_result_valid_r)
        else $error("no result");
    a_grp_accept: assert property (
        rx_result_valid_r |-> rx_group_accept_r == acc_r)
        else $error("group accept");
    a_sta_match: assert property (
        rx_result_valid_r |-> rx_station_match_r == sm_r)
        else $error("station match");
    a_mdc_half: assert property (
        $rose(mdc) |-> ##9 mdc ##1 !mdc) else $error("mdc half period");
    a_mdio_steady: assert property (
        mdc && $past(mdc) |-> $stable(mdio_o) && $stable(mdio_oe))
        else $error("mdio moved");
    c_accept: cover property (rx_group_accept_r);
    c_error: cover property (pslverr);
    c_turn: cover property ($fell(mdio_oe));
endmodule // maf_chk
bind maf_top maf_chk u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .guard_rst_n(guard_rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_check(rx_check), .rx_dest_addr(rx_dest_addr),
    .rx_hash_index(rx_hash_index), .rx_result_valid_r(rx_result_valid_r),
    .rx_station_match_r(rx_station_match_r),
    .rx_group_frame_r(rx_group_frame_r),
    .rx_group_accept_r(rx_group_accept_r), .mdc(mdc), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .mdio_i(mdio_i)
);
`default_nettype wire

// ===== verification/maf_phy_model.sv
// behavioural management responder in place of the internal phy
`timescale 1ns/100ps
`default_nettype none
module maf_phy_model (
    // management clock and wire level
    input wire logic mdc,
    input wire logic mdio,
    // phy drive of the wire
    output logic phy_o,
    output logic phy_oe
);
    logic [15:0] mem [0:31]; // phy register set
    logic [15:0] sh_r = 16'h0; // bit collector
    logic [11:0] hdr_r = 12'h0; // op, phy address, index
    logic [6:0] p_r = 7'd0; // next frame bit position
    logic act_r = 1'b0; // frame in progress
    logic rd; // read aimed at phy address one
    assign rd = hdr_r[11:10] == 2'b10 && hdr_r[9:5] == 5'h01;
    // sample the wire on each rising edge
    always @(posedge mdc) begin
        sh_r <= {sh_r[14:0], mdio};
        if (!act_r && sh_r == 16'hFFFE && mdio) begin
            act_r <= 1'b1;
            p_r <= 7'd34;
        end else if (act_r) begin
            p_r <= p_r + 7'd1;
            if (p_r == 7'd45) hdr_r <= {sh_r[10:0], mdio};
            if (p_r == 7'd63) act_r <= 1'b0;
            if (p_r == 7'd63 && hdr_r[11:5] == 7'h21)
                mem[hdr_r[4:0]] <= {sh_r[14:0], mdio};
        end
    end
    // turnaround zero then read data after falling edges
    always @(negedge mdc) begin
        phy_oe <= act_r && rd && p_r >= 7'd47;
        phy_o <= (p_r == 7'd47) ? 1'b0 : mem[hdr_r[4:0]][7'd63 - p_r];
    end
endmodule // maf_phy_model
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the filter and management register block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic core_clk, rst_n, guard_rst_n; // clock and resets
    logic psel, penable, pwrite, pready, pslverr; // apb
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v; // rd_v is last read
    logic rd_err; // last slave error
    logic rx_check, rx_val, rx_sm, rx_grp, rx_acc; // receive check
    logic [47:0] rx_dest_addr;
    logic [5:0] rx_hash_index;
    logic mdc, mdio_o, mdio_oe, mdio_w, phy_o, phy_oe; // management
    int n_fail, checks;
    // wire with pull-up
    assign mdio_w = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);
    maf_top DUT (.core_clk(core_clk), .rst_n(rst_n),
        .guard_rst_n(guard_rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_check(rx_check),
        .rx_dest_addr(rx_dest_addr), .rx_hash_index(rx_hash_index),
        .rx_result_valid_r(rx_val), .rx_station_match_r(rx_sm),
        .rx_group_frame_r(rx_grp), .rx_group_accept_r(rx_acc), .mdc(mdc),
        .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdio_i(mdio_w));
    maf_phy_model u_phy (.mdc(mdc), .mdio(mdio_w), .phy_o(phy_o),
        .phy_oe(phy_oe));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until ready
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) n_fail++;
        rd_v = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rd_v, exp);
    endtask
    task automatic pulse(input logic g);
        @(posedge core_clk);
        if (g) guard_rst_n <= 1'b0;
        else rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        guard_rst_n <= 1'b1;
        rst_n <= 1'b1;
    endtask
    task automatic probe(input logic [47:0] d, input logic [5:0] ix,
        input logic sm, input logic acc);
        @(posedge core_clk);
        rx_check <= 1'b1;
        rx_dest_addr <= d;
        rx_hash_index <= ix;
        @(posedge core_clk);
        rx_check <= 1'b0;
        @(posedge core_clk);
        cmp({28'h0, rx_val, rx_grp, rx_sm, rx_acc},
            {28'h0, 1'b1, d[0], sm, acc});
    endtask
    task automatic t_regs();
        logic [11:0] rw [3] = '{12'h108, 12'h10C, 12'h110};
        rd(12'h104, 32'h0000FFFF);
        rd(12'h108, 32'hFFFFFFFF);
        rd(12'h110, 32'h0);
        rd(12'h118, 32'h0);
        apb(1'b1, 12'h104, 32'hA5A55A5A);
        rd(12'h104, 32'h00005A5A);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, rw[i], 32'hA5A55A5A);
            rd(rw[i], 32'hA5A55A5A);
        end
        apb(1'b1, 12'h118, 32'hA5A55A5A);
        rd(12'h118, 32'h00005A5A);
        rd(12'h100, 32'h0);
        cmp({31'h0, rd_err}, 32'h1);
        pulse(1'b0);
        rd(12'h108, 32'hA5A55A5A);
        rd(12'h10C, 32'h0);
        pulse(1'b1);
        rd(12'h104, 32'h0000FFFF);
    endtask
    task automatic t_filter();
        logic [5:0] ix [4] = '{6'h00, 6'h3F, 6'h1F, 6'h20};
        apb(1'b1, 12'h108, 32'h78563412);
        apb(1'b1, 12'h104, 32'h0000BC9A);
        probe(48'hBC9A78563412, 6'h00, 1'b1, 1'b0);
        probe(48'hBD9A78563412, 6'h00, 1'b0, 1'b0);
        apb(1'b1, 12'h110, 32'h00000001);
        apb(1'b1, 12'h10C, 32'h80000000);
        for (int i = 0; i < 4; i++)
            probe(48'h1, ix[i], 1'b0, i < 2);
        apb(1'b1, 12'h0F8, 32'h1);
        probe(48'h1, 6'h1F, 1'b0, 1'b1);
        probe(48'h2, 6'h00, 1'b0, 1'b0);
        apb(1'b1, 12'h0F8, 32'h0);
    endtask
    task automatic mgmt(input logic w, input logic [4:0] ri,
        input logic [15:0] d);
        int n;
        n = 0;
        if (w) apb(1'b1, 12'h118, {16'h0, d});
        apb(1'b1, 12'h114, {16'h0, 5'h01, ri, 4'h0, w, 1'b1});
        rd(12'h114, {16'h0, 5'h01, ri, 4'h0, w, 1'b1});
        apb(1'b1, 12'h118, 32'h00000F0F);
        do begin
            apb(1'b0, 12'h114, 32'h0);
            n++;
        end while (rd_v[0] !== 1'b0 && n < 1000);
        cmp({31'h0, rd_v[0]}, 32'h0);
        rd(12'h118, {16'h0, d});
    endtask
    task automatic test_done();
        if (n_fail == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // watchdog against a hung wait
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        test_done();
    end
    // main sequence
    initial begin
        {rst_n, guard_rst_n, psel, penable, pwrite, rx_check} = 6'h0;
        {paddr, pwdata, rx_dest_addr, rx_hash_index} = 98'h0;
        n_fail = 0;
        checks = 0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        guard_rst_n <= 1'b1;
        t_regs();
        t_filter();
        mgmt(1'b1, 5'h05, 16'hBEEF);
        mgmt(1'b1, 5'h06, 16'h1234);
        mgmt(1'b0, 5'h05, 16'hBEEF);
        mgmt(1'b0, 5'h06, 16'h1234);
        cmp({31'h0, mdc}, 32'h0);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
